/* File: hw/rdp_pkg.sv */
// Package for the residual differential protection stage.
// Assumes a 200 MHz program clock and 16-bit magnitudes in 0.01 x In units.
package rdp_pkg;
   // ----------------------------------------------------------------
   // Widths and timing
   // ----------------------------------------------------------------
   localparam int MAG_W = 16;
   localparam int ANG_W = 8;
   localparam int REC_W = 20;
   localparam int NUM_GROUPS = 8;
   localparam int GRP_WORDS = 6;
   localparam int CLK_HZ = 200_000_000;
   localparam int STAMP_MS = 1;
   localparam int MS_CYCLES = CLK_HZ / 1000 * STAMP_MS;
   localparam int SLOPE_DIV = 10000;
   localparam int SAMPLE_MS = 5;

   // ----------------------------------------------------------------
   // Channel indices
   // ----------------------------------------------------------------
   localparam int CH_A = 0;
   localparam int CH_B = 1;
   localparam int CH_C = 2;
   localparam int CH_R1 = 3;
   localparam int CH_R2 = 4;
   localparam int NUM_CH = 5;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [9:0] REG_CTRL = 10'h000;
   localparam logic [9:0] REG_STATUS = 10'h004;
   localparam logic [9:0] REG_IRQ_STAT = 10'h008;
   localparam logic [9:0] REG_IRQ_MASK = 10'h00c;
   localparam logic [9:0] REG_CNT_REF = 10'h010;
   localparam logic [9:0] REG_CNT_TRIP = 10'h014;
   localparam logic [9:0] REG_CNT_BLK = 10'h018;
   localparam logic [9:0] REG_EVENT = 10'h01c;
   localparam logic [9:0] REG_DIFF = 10'h020;
   localparam logic [9:0] REG_BIAS = 10'h024;
   localparam logic [9:0] REG_CALC = 10'h028;
   localparam logic [9:0] REG_GRP_BASE = 10'h100;
   localparam logic [9:0] REG_GRP_END = 10'h200;

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   localparam int CTRL_FORCE_EN = 0;
   localparam int CTRL_FORCE_LO = 1;
   localparam int CTRL_CABLE_END = 3;
   localparam int CTRL_COMP = 4;

   // Group words and option bits
   localparam int GW_PICKUP = 0;
   localparam int GW_KNEE1 = 1;
   localparam int GW_KNEE2 = 2;
   localparam int GW_SLOPE1 = 3;
   localparam int GW_SLOPE2 = 4;
   localparam int GW_OPT = 5;
   localparam int OPT_INPUT = 0;
   localparam int OPT_DIR = 1;
   localparam int OPT_BIAS = 2;

   // Group reset values
   localparam logic [15:0] DEF_PICKUP = 16'h000a;
   localparam logic [15:0] DEF_KNEE1 = 16'h0064;
   localparam logic [15:0] DEF_KNEE2 = 16'h012c;
   localparam logic [15:0] DEF_SLOPE1 = 16'h03e8;
   localparam logic [15:0] DEF_SLOPE2 = 16'h0fa0;
   localparam logic [15:0] DEF_OPT = 16'h0000;

   // Interrupt / event bits
   localparam int EV_TRIP_ON = 0;
   localparam int EV_TRIP_OFF = 1;
   localparam int EV_BLK_ON = 2;
   localparam int EV_BLK_OFF = 3;
   localparam int EV_W = 4;

   typedef enum logic [1:0] {
      COND_NORMAL,
      COND_TRIP,
      COND_BLOCKED
   } rdp_cond_e;

   typedef struct packed {
      logic [MAG_W-1:0] mag;
      logic [ANG_W-1:0] ang;
   } rdp_chan_s;

   typedef struct packed {
      logic valid;
      logic [EV_W-1:0] flags;
      logic [31:0] stamp;
   } rdp_event_s;
endpackage : rdp_pkg

/* File: hw/rdp_phasor.sv */
// Polar to rectangular conversion of one current phasor.
// Assumes angle in 1/256 turn; resolution is kept to 1/64 turn.
`timescale 1ns/100ps
`default_nettype none
module rdp_phasor
   import rdp_pkg::*;
(
   // Polar input
   input wire rdp_pkg::rdp_chan_s chan_i,
   // Rectangular output
   output logic signed [rdp_pkg::REC_W-1:0] re_o,
   output logic signed [rdp_pkg::REC_W-1:0] im_o
);
   // ----------------------------------------------------------------
   // Quarter-wave sine, Q14
   // ----------------------------------------------------------------
   function automatic logic [14:0] quarter(input logic [4:0] k);
      case (k)
         5'd0: quarter = 15'h0000;
         5'd1: quarter = 15'h0646;
         5'd2: quarter = 15'h0c7c;
         5'd3: quarter = 15'h1294;
         5'd4: quarter = 15'h187e;
         5'd5: quarter = 15'h1e2b;
         5'd6: quarter = 15'h238e;
         5'd7: quarter = 15'h289a;
         5'd8: quarter = 15'h2d41;
         5'd9: quarter = 15'h3179;
         5'd10: quarter = 15'h3537;
         5'd11: quarter = 15'h3871;
         5'd12: quarter = 15'h3b21;
         5'd13: quarter = 15'h3d3f;
         5'd14: quarter = 15'h3ec5;
         5'd15: quarter = 15'h3fb1;
         default: quarter = 15'h4000;
      endcase
   endfunction : quarter

   function automatic logic signed [REC_W-1:0] project(
      input logic [MAG_W-1:0] mag, input logic [ANG_W-1:0] ang);
      logic [4:0] k;
      logic [30:0] prod;
      logic signed [REC_W-1:0] amp;
      k = ang[6] ? 5'h10 - {1'b0, ang[5:2]} : {1'b0, ang[5:2]};
      prod = 31'(mag) * 31'(quarter(k));
      amp = REC_W'(signed'({1'b0, prod[30:14]}));
      project = ang[7] ? -amp : amp;
   endfunction : project

   localparam logic [ANG_W-1:0] QUARTER_TURN = 8'h40;
   assign im_o = project(chan_i.mag, chan_i.ang);
   assign re_o = project(chan_i.mag, chan_i.ang + QUARTER_TURN);
endmodule : rdp_phasor
`default_nettype wire

/* File: hw/rdp_char.sv */
// Two-slope differential characteristic comparator.
// Assumes currents in 0.01 x In and slopes in 0.01 %.
`timescale 1ns/100ps
`default_nettype none
module rdp_char
   import rdp_pkg::*;
(
   // Operating point
   input wire logic [rdp_pkg::MAG_W-1:0] diff_i,
   input wire logic [rdp_pkg::MAG_W-1:0] bias_i,
   // Characteristic settings
   input wire logic [rdp_pkg::MAG_W-1:0] pickup_i,
   input wire logic [rdp_pkg::MAG_W-1:0] knee1_i,
   input wire logic [rdp_pkg::MAG_W-1:0] knee2_i,
   input wire logic [rdp_pkg::MAG_W-1:0] slope1_i,
   input wire logic [rdp_pkg::MAG_W-1:0] slope2_i,
   // Result
   output logic pick_o
);
   wire logic [MAG_W-1:0] top1 = (bias_i > knee2_i) ? knee2_i : bias_i;
   wire logic [MAG_W-1:0] seg1 = (top1 > knee1_i) ? top1 - knee1_i : '0;
   wire logic [MAG_W-1:0] seg2 = (bias_i > knee2_i) ? bias_i - knee2_i : '0;
   wire logic [31:0] rise1 = (32'(slope1_i) * 32'(seg1)) / 32'(SLOPE_DIV);
   wire logic [31:0] rise2 = (32'(slope2_i) * 32'(seg2)) / 32'(SLOPE_DIV);
   wire logic [33:0] thresh = 34'(pickup_i) + 34'(rise1) + 34'(rise2);
   // Flat, first slope, then second slope stacked on the first
   assign pick_o = 34'(diff_i) > thresh;
endmodule : rdp_char
`default_nettype wire

/* File: hw/rdp_top.sv */
// Residual differential protection stage with Avalon-MM registers.
// Assumes measurement sets arrive as one-cycle strobes every 5 ms and
// that group select and block come from logic on the same clock.
//
// Function
// - Differential is phase vector sum combined with the selected residual.
// - Tracks calculated residual plus bias and differential.
// - Eight setting groups chosen by one shared selector.
// - Block and group changes take effect live, no restart.
// - Trip and blocked outputs with ON/OFF events, millisecond stamps.
// - Resettable counters of pick-ups, trips and blocks.
// - Uses RMS magnitudes and angles, refreshed every 5 ms.
// - Calculated and measured residual both used; setting picks input.
// - Cable-end mode: no differential without measured residual.
// - Status forcing 0 normal, 1 trip, 2 blocked when forcing enabled.
// - General settings live outside the setting groups.
// - Mode 0 restricted earth fault, mode 1 cable-end differential.
// - Compensation stores calculated residual as offset, cable-end only.
// - Order: select, process, compare, block check, output.
// - Threshold flat, then first slope, then added second slope.
// - Direction setting: 0 adds, 1 subtracts measured residual.
// - Bias is average of residuals or maximum of phase and selected residual magnitudes.
// - Pick-up trips unless blocked; late block clears trip.
`timescale 1ns/100ps
`default_nettype none
module rdp_top
   import rdp_pkg::*;
#(
   parameter int MS_COUNT = rdp_pkg::MS_CYCLES,
   parameter logic [15:0] ENERGIZED_MIN = 16'h0005
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Measurement front end
   input wire logic sample_valid_i,
   input wire rdp_pkg::rdp_chan_s [rdp_pkg::NUM_CH-1:0] chan_i,
   // Common selector and blocking matrix
   input wire logic [2:0] group_sel_i,
   input wire logic block_i,
   // Avalon-MM slave
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Protection outputs
   output logic trip_o,
   output logic blocked_o,
   output logic irq_o,
   output rdp_pkg::rdp_event_s event_o
);
   initial begin
      if (MS_COUNT < 1 || NUM_GROUPS != 8)
         $error("rdp_top: unsupported parameters");
   end

   function automatic logic [MAG_W-1:0] sat(input logic [REC_W:0] v);
      sat = (v > (REC_W+1)'(16'hffff)) ? 16'hffff : v[MAG_W-1:0];
   endfunction : sat

   // Magnitude of a rectangular pair: max + 3/8 min
   function automatic logic [MAG_W-1:0] vmag(
      input logic signed [REC_W-1:0] re, input logic signed [REC_W-1:0] im);
      logic [REC_W:0] a;
      logic [REC_W:0] b;
      a = (REC_W+1)'(re < 0 ? -re : re);
      b = (REC_W+1)'(im < 0 ? -im : im);
      if (a < b) vmag = sat(b + ((a + (a << 1)) >> 3));
      else vmag = sat(a + ((b + (b << 1)) >> 3));
   endfunction : vmag

   // ----------------------------------------------------------------
   // Settings storage
   // ----------------------------------------------------------------
   logic [15:0] grp_mem [NUM_GROUPS][GRP_WORDS];
   logic force_en;
   logic [1:0] force_code;
   logic cable_end_mode;
   logic [EV_W-1:0] irq_stat;
   logic [EV_W-1:0] irq_mask;
   logic [31:0] cnt_ref, cnt_trip, cnt_blk;
   logic signed [REC_W-1:0] off_re, off_im;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire logic req = avs_read_i | avs_write_i;
   wire logic take = req & ~avs_waitrequest_o;
   wire logic wr = take & avs_write_i;
   wire logic in_grp = avs_address_i >= REG_GRP_BASE &&
                       avs_address_i < REG_GRP_END;
   wire logic [2:0] a_grp = avs_address_i[7:5];
   wire logic [2:0] a_word = avs_address_i[4:2];
   wire logic grp_hit = in_grp && a_word < 3'(GRP_WORDS);
   wire logic wr_ctrl = wr && avs_address_i == REG_CTRL;
   wire logic wr_irqs = wr && avs_address_i == REG_IRQ_STAT;

   // ----------------------------------------------------------------
   // Stage 1: input selection, group latched per sample strobe
   // ----------------------------------------------------------------
   logic s1, s2, s3, s4;
   logic [2:0] grp;
   rdp_chan_s [3:0] sel;
   logic blk_latched;
   wire logic [15:0] opt = grp_mem[group_sel_i][GW_OPT];

   always_ff @(posedge ref_clk_i) begin
      s1 <= ~rst_i & sample_valid_i;
      if (sample_valid_i) begin
         grp <= group_sel_i;
         blk_latched <= block_i;
         sel[CH_A] <= chan_i[CH_A];
         sel[CH_B] <= chan_i[CH_B];
         sel[CH_C] <= chan_i[CH_C];
         sel[CH_R1] <= opt[OPT_INPUT] ? chan_i[CH_R2] : chan_i[CH_R1];
      end
   end

   logic signed [REC_W-1:0] rx_re [4], rx_im [4];
   for (genvar i = 0; i < 4; i++) begin : g_ph
      rdp_phasor u_ph (
         .chan_i(sel[i]),
         .re_o(rx_re[i]),
         .im_o(rx_im[i])
      );
   end

   // ----------------------------------------------------------------
   // Stage 2: magnitude processing
   // ----------------------------------------------------------------
   wire logic [15:0] gopt = grp_mem[grp][GW_OPT];
   wire logic signed [REC_W-1:0] sum_re = rx_re[CH_A] + rx_re[CH_B] + rx_re[CH_C];
   wire logic signed [REC_W-1:0] sum_im = rx_im[CH_A] + rx_im[CH_B] + rx_im[CH_C];
   wire logic signed [REC_W-1:0] calc_re = cable_end_mode ? sum_re - off_re : sum_re;
   wire logic signed [REC_W-1:0] calc_im = cable_end_mode ? sum_im - off_im : sum_im;
   wire logic signed [REC_W-1:0] dif_re = gopt[OPT_DIR] ?
      calc_re - rx_re[CH_R1] : calc_re + rx_re[CH_R1];
   wire logic signed [REC_W-1:0] dif_im = gopt[OPT_DIR] ?
      calc_im - rx_im[CH_R1] : calc_im + rx_im[CH_R1];
   wire logic meas_ok = sel[CH_R1].mag != '0;
   wire logic [15:0] calc_mag = vmag(calc_re, calc_im);
   wire logic [16:0] avg_sum = 17'(calc_mag) + 17'(sel[CH_R1].mag);
   wire logic [15:0] ph_ab = sel[CH_A].mag > sel[CH_B].mag ? sel[CH_A].mag : sel[CH_B].mag;
   wire logic [15:0] ph_max = ph_ab > sel[CH_C].mag ? ph_ab : sel[CH_C].mag;
   wire logic [15:0] all_max = ph_max > sel[CH_R1].mag ? ph_max : sel[CH_R1].mag;
   wire logic energized = ph_max >= ENERGIZED_MIN;
   logic [15:0] diff_mag, bias_mag, calc_seen;

   always_ff @(posedge ref_clk_i) begin
      s2 <= ~rst_i & s1;
      if (s1) begin
         // Cable-end without measured residual gives no differential
         diff_mag <= (cable_end_mode && !meas_ok) ? '0 : vmag(dif_re, dif_im);
         bias_mag <= gopt[OPT_BIAS] ? all_max : avg_sum[16:1];
         calc_seen <= calc_mag;
      end
   end

   // ----------------------------------------------------------------
   // Stage 3: characteristic comparison
   // ----------------------------------------------------------------
   wire logic pick_now;
   logic pick;
   rdp_char u_char (
      .diff_i(diff_mag),
      .bias_i(bias_mag),
      .pickup_i(grp_mem[grp][GW_PICKUP]),
      .knee1_i(grp_mem[grp][GW_KNEE1]),
      .knee2_i(grp_mem[grp][GW_KNEE2]),
      .slope1_i(grp_mem[grp][GW_SLOPE1]),
      .slope2_i(grp_mem[grp][GW_SLOPE2]),
      .pick_o(pick_now)
   );

   // ----------------------------------------------------------------
   // Stage 4: block check and forcing
   // ----------------------------------------------------------------
   rdp_cond_e cond, next_cond;
   always_comb begin
      if (force_en) begin
         case (force_code)
            2'h1: next_cond = COND_TRIP;
            2'h2: next_cond = COND_BLOCKED;
            default: next_cond = COND_NORMAL;
         endcase
      end else if (!pick) next_cond = COND_NORMAL;
      else if (blk_latched) next_cond = COND_BLOCKED;
      else next_cond = COND_TRIP;
   end

   always_ff @(posedge ref_clk_i) begin
      s3 <= ~rst_i & s2;
      s4 <= ~rst_i & s3;
      if (rst_i) begin
         pick <= 1'b0;
         cond <= COND_NORMAL;
      end else begin
         if (s2) pick <= pick_now;
         if (s3) cond <= next_cond;
      end
   end

   // ----------------------------------------------------------------
   // Stage 5: outputs, events, counters
   // ----------------------------------------------------------------
   logic [31:0] ms_cnt, stamp;
   logic pick_prev;
   wire logic new_trip = cond == COND_TRIP;
   wire logic new_blk = cond == COND_BLOCKED;
   wire logic [EV_W-1:0] ev = s4 ? {blocked_o & ~new_blk, ~blocked_o & new_blk,
                                    trip_o & ~new_trip, ~trip_o & new_trip} : '0;
   wire logic ref_op = s4 & pick & ~pick_prev;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ms_cnt <= '0;
         stamp <= '0;
         trip_o <= 1'b0;
         blocked_o <= 1'b0;
         pick_prev <= 1'b0;
         event_o <= '0;
      end else begin
         // Stamp counts milliseconds since reset
         if (ms_cnt == 32'(MS_COUNT - 1)) begin
            ms_cnt <= '0;
            stamp <= stamp + 32'h1;
         end else ms_cnt <= ms_cnt + 32'h1;
         if (s4) begin
            trip_o <= new_trip;
            blocked_o <= new_blk;
            pick_prev <= pick;
         end
         event_o.valid <= |ev;
         event_o.flags <= ev;
         event_o.stamp <= stamp;
      end
   end

   // ----------------------------------------------------------------
   // Register writes and counters
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         force_en <= 1'b0;
         force_code <= 2'h0;
         cable_end_mode <= 1'b0;
         irq_stat <= '0;
         irq_mask <= '0;
         off_re <= '0;
         off_im <= '0;
         cnt_ref <= '0;
         cnt_trip <= '0;
         cnt_blk <= '0;
         for (int g = 0; g < NUM_GROUPS; g++) begin
            grp_mem[g][GW_PICKUP] <= DEF_PICKUP;
            grp_mem[g][GW_KNEE1] <= DEF_KNEE1;
            grp_mem[g][GW_KNEE2] <= DEF_KNEE2;
            grp_mem[g][GW_SLOPE1] <= DEF_SLOPE1;
            grp_mem[g][GW_SLOPE2] <= DEF_SLOPE2;
            grp_mem[g][GW_OPT] <= DEF_OPT;
         end
      end else begin
         if (wr_ctrl) begin
            force_en <= avs_writedata_i[CTRL_FORCE_EN];
            // Forcing code only accepted while forcing is enabled
            if (avs_writedata_i[CTRL_FORCE_EN])
               force_code <= avs_writedata_i[CTRL_FORCE_LO +: 2];
            cable_end_mode <= avs_writedata_i[CTRL_CABLE_END];
            if (avs_writedata_i[CTRL_COMP] && energized) begin
               off_re <= sum_re;
               off_im <= sum_im;
            end
         end
         if (wr && grp_hit)
            grp_mem[a_grp][a_word] <= avs_writedata_i[15:0];
         if (wr && avs_address_i == REG_IRQ_MASK)
            irq_mask <= avs_writedata_i[EV_W-1:0];
         // New events win over a simultaneous write-one clear
         irq_stat <= (irq_stat & ~(wr_irqs ? avs_writedata_i[EV_W-1:0] : '0)) | ev;
         if (wr && avs_address_i == REG_CNT_REF) cnt_ref <= '0;
         else if (ref_op) cnt_ref <= cnt_ref + 32'h1;
         if (wr && avs_address_i == REG_CNT_TRIP) cnt_trip <= '0;
         else if (ev[EV_TRIP_ON]) cnt_trip <= cnt_trip + 32'h1;
         if (wr && avs_address_i == REG_CNT_BLK) cnt_blk <= '0;
         else if (ev[EV_BLK_ON]) cnt_blk <= cnt_blk + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // Read mux and handshake
   // ----------------------------------------------------------------
   logic [31:0] rd;
   always_comb begin
      if (avs_address_i == REG_CTRL)
         rd = {28'h0, cable_end_mode, force_code, force_en};
      else if (avs_address_i == REG_STATUS)
         rd = {28'h0, blocked_o | trip_o, pick, cond};
      else if (avs_address_i == REG_IRQ_STAT) rd = {28'h0, irq_stat};
      else if (avs_address_i == REG_IRQ_MASK) rd = {28'h0, irq_mask};
      else if (avs_address_i == REG_CNT_REF) rd = cnt_ref;
      else if (avs_address_i == REG_CNT_TRIP) rd = cnt_trip;
      else if (avs_address_i == REG_CNT_BLK) rd = cnt_blk;
      else if (avs_address_i == REG_EVENT) rd = event_o.stamp;
      else if (avs_address_i == REG_DIFF) rd = {16'h0, diff_mag};
      else if (avs_address_i == REG_BIAS) rd = {16'h0, bias_mag};
      else if (avs_address_i == REG_CALC) rd = {16'h0, calc_seen};
      else if (grp_hit) rd = {16'h0, grp_mem[a_grp][a_word]};
      else rd = 32'h0;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= '0;
         irq_o <= 1'b0;
      end else begin
         // One wait cycle, then a single acknowledge cycle
         avs_waitrequest_o <= ~(req & avs_waitrequest_o);
         if (req & avs_waitrequest_o) avs_readdata_o <= rd;
         irq_o <= |(irq_stat & irq_mask);
      end
   end
endmodule : rdp_top
`default_nettype wire

/* File: tb/rdp_front.sv */
// Measurement front end model: one strobe per requested set.
// Assumes the bench raises go_i for one cycle per set.
`timescale 1ns/100ps
`default_nettype none
module rdp_front
   import rdp_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic go_i,
   input wire rdp_pkg::rdp_chan_s [rdp_pkg::NUM_CH-1:0] set_i,
   output logic sample_valid_o,
   output rdp_pkg::rdp_chan_s [rdp_pkg::NUM_CH-1:0] chan_o
);
   initial begin
      sample_valid_o = 1'b0;
      chan_o = '0;
   end
   // Outside the strobe the set is stale: show churn, not old data
   always @(posedge ref_clk_i) begin
      sample_valid_o <= go_i;
      chan_o <= go_i ? set_i : ~chan_o;
   end
endmodule : rdp_front
`default_nettype wire

/* File: tb/rdp_top_properties.sv */
// Port-level checker for the protection stage.
// Assumes the Avalon master drops its request after each answer.
`timescale 1ns/100ps
`default_nettype none
module rdp_top_properties
   import rdp_pkg::*;
#(
   parameter int MS_COUNT = 10
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic sample_valid_i,
   input wire rdp_pkg::rdp_chan_s [rdp_pkg::NUM_CH-1:0] chan_i,
   input wire logic [2:0] group_sel_i,
   input wire logic block_i,
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic trip_o,
   input wire logic blocked_o,
   input wire logic irq_o,
   input wire rdp_pkg::rdp_event_s event_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   property p_wait_one;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("bus answer late");
   property p_wait_pulse;
      !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse)
      else $error("waitrequest low too long");
   property p_unmapped;
      avs_read_i && !avs_waitrequest_o && avs_address_i == 10'h3fc
         |-> avs_readdata_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_excl;
      !(trip_o && blocked_o);
   endproperty
   a_excl: assert property (p_excl)
      else $error("trip and blocked together");
   property p_ev_follow;
      $changed(trip_o) || $changed(blocked_o) |-> event_o.valid;
   endproperty
   a_ev_follow: assert property (p_ev_follow)
      else $error("output change without event");
   property p_ev_trip_on;
      event_o.valid && event_o.flags[EV_TRIP_ON] |-> trip_o && !$past(trip_o);
   endproperty
   a_ev_trip_on: assert property (p_ev_trip_on)
      else $error("trip on event mismatch");
   property p_ev_blk_off;
      event_o.valid && event_o.flags[EV_BLK_OFF] |-> !blocked_o;
   endproperty
   a_ev_blk_off: assert property (p_ev_blk_off)
      else $error("blocked off event mismatch");
   property p_blk_lat;
      $rose(blocked_o) |-> $past(sample_valid_i, 5);
   endproperty
   a_blk_lat: assert property (p_blk_lat)
      else $error("blocked not five cycles after strobe");
endmodule : rdp_top_properties
bind rdp_top rdp_top_properties #(.MS_COUNT(MS_COUNT)) u_props (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sample_valid_i(sample_valid_i),
   .chan_i(chan_i), .group_sel_i(group_sel_i), .block_i(block_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .trip_o(trip_o), .blocked_o(blocked_o), .irq_o(irq_o), .event_o(event_o));
`default_nettype wire

/* File: tb/rdp_top_tb.sv */
// Bench for the protection stage: Avalon tasks plus sample sets.
// Assumes a 10-cycle millisecond count to keep stamps small.
`timescale 1ns/100ps
`default_nettype none
module rdp_top_tb;
   import rdp_pkg::*;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, go = 1'b0, block = 1'b0;
   logic sv, rd_i = 1'b0, wr_i = 1'b0, wq, trip, blk, irq;
   logic [2:0] grp = 3'h0;
   logic [9:0] adr = 10'h0;
   logic [31:0] wd = 32'h0, q;
   rdp_chan_s [NUM_CH-1:0] set = '0, chan;
   rdp_event_s ev;
   logic [EV_W-1:0] evf = '0;
   int errors = 0, total_checks = 0;
   logic [15:0] dv [5] = '{DEF_PICKUP, DEF_KNEE1, DEF_KNEE2, DEF_SLOPE1,
      DEF_SLOPE2};
   initial forever #2.5 ref_clk_i = ~ref_clk_i;
   // Event pulse lasts one cycle: keep the last flags for later compare
   always @(posedge ref_clk_i) begin
      if (ev.valid) evf <= ev.flags;
   end
   rdp_front u_front (.ref_clk_i(ref_clk_i), .go_i(go), .set_i(set),
      .sample_valid_o(sv), .chan_o(chan));
   rdp_top #(.MS_COUNT(10)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .sample_valid_i(sv), .chan_i(chan), .group_sel_i(grp),
      .block_i(block), .avs_address_i(adr), .avs_read_i(rd_i),
      .avs_write_i(wr_i), .avs_writedata_i(wd), .avs_readdata_o(q),
      .avs_waitrequest_o(wq), .trip_o(trip), .blocked_o(blk), .irq_o(irq),
      .event_o(ev));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [9:0] a,
         input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      adr <= a;
      wr_i <= w;
      rd_i <= !w;
      wd <= d;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (wq !== 1'b0 && n < 50);
      r = q;
      if (n >= 50) errors++;
      rd_i <= 1'b0;
      wr_i <= 1'b0;
   endtask : bus
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask : rd
   // Phases B, C and all angles stay zero
   task automatic smp(input logic [15:0] a, r1, r2, input logic [2:0] g,
         input logic b);
      rdp_chan_s [NUM_CH-1:0] s;
      s = '0;
      s[CH_A].mag = a;
      s[CH_R1].mag = r1;
      s[CH_R2].mag = r2;
      @(posedge ref_clk_i);
      set <= s;
      grp <= g;
      block <= b;
      go <= 1'b1;
      @(posedge ref_clk_i);
      go <= 1'b0;
      repeat (9) @(posedge ref_clk_i);
   endtask : smp
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      errors++;
      test_done();
   end
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rd(REG_STATUS, 32'h0);
      for (int w = 0; w < 5; w++) begin
         rd(REG_GRP_BASE + 10'(w * 4), {16'h0, dv[w]});
         rd(REG_GRP_BASE + 10'(224 + w * 4), {16'h0, dv[w]});
      end
      rd(10'h118, 32'h0);
      rd(10'h3fc, 32'h0);
      wr(REG_IRQ_MASK, 32'h1);
      smp(16'd0, 16'd50, 16'd0, 3'd0, 1'b0);
      chk(trip, 1'b1);
      chk(irq, 1'b1);
      rd(REG_IRQ_STAT, 32'h1);
      rd(REG_CNT_TRIP, 32'h1);
      wr(REG_IRQ_STAT, 32'h1);
      repeat (3) @(posedge ref_clk_i);
      chk(irq, 1'b0);
      smp(16'd0, 16'd50, 16'd0, 3'd0, 1'b1);
      chk({trip, blk}, 2'b01);
      chk(evf, 4'h6);
      rd(REG_CNT_BLK, 32'h1);
      wr(REG_CNT_BLK, 32'h0);
      rd(REG_CNT_BLK, 32'h0);
      wr(REG_GRP_BASE + 10'h020, 32'd200);
      smp(16'd0, 16'd50, 16'd0, 3'd1, 1'b0);
      chk({trip, blk}, 2'b00);
      smp(16'd0, 16'd50, 16'd0, 3'd0, 1'b0);
      chk(trip, 1'b1);
      wr(REG_GRP_BASE + 10'h014, 32'h2);
      smp(16'd50, 16'd50, 16'd0, 3'd0, 1'b0);
      chk(trip, 1'b0);
      wr(REG_GRP_BASE + 10'h054, 32'h6);
      smp(16'd400, 16'd335, 16'd0, 3'd2, 1'b0);
      chk(trip, 1'b0);
      smp(16'd400, 16'd325, 16'd0, 3'd2, 1'b0);
      chk(trip, 1'b1);
      wr(REG_GRP_BASE + 10'h014, 32'h1);
      wr(REG_CTRL, 32'h8);
      smp(16'd50, 16'd0, 16'd0, 3'd0, 1'b0);
      chk(trip, 1'b0);
      wr(REG_CTRL, 32'h18);
      smp(16'd50, 16'd0, 16'd10, 3'd0, 1'b0);
      chk(trip, 1'b0);
      rd(REG_CALC, 32'h0);
      wr(REG_CTRL, 32'hd);
      smp(16'd50, 16'd0, 16'd0, 3'd0, 1'b0);
      chk(blk, 1'b1);
      rd(REG_STATUS, 32'ha);
      test_done();
   end
endmodule : rdp_top_tb
`default_nettype wire
